//--- hdl/plo_lane_output.sv
`timescale 1ns/1ps

// How it works
// - Lanes zero to fifteen also drive the optical transmitter outputs.
// - Thirty-two electrical lanes: 0-15 first connector, 16-31 second connector.
// - After reset, pairs of lanes form channels in complementary mode.
// - Complementary mode drives inverse gates with dead time, never both high.
// - Authorization mode: switching waveform on one lane, enable level on other.
// - Independent mode: each lane follows its own modulator, no dead time.
// - Software-written dead time applies to both transitions of a pair.
// - Optical and electrical copies of a lane carry the same state.
// - A protection trip blocks all lanes at once and enters fault state.
module plo_lane_output
	import plo_pkg::*;
#(
	parameter int DT_W = DT_WIDTH
) (
	// Clock and reset
	input  wire logic                clock,
	input  wire logic                reset,
	// Configuration
	input  wire plo_mode_e           mode,
	input  wire logic [DT_W-1:0]     dead_time,
	// Modulator results
	input  wire logic [LANES-1:0]    modulator,
	input  wire logic [CHANNELS-1:0] authorize,
	// Protection
	input  wire logic                trip,
	input  wire logic                fault_clear,
	// Lane outputs
	output logic [LANES-1:0]         elec_lane,
	output logic [OPTICAL_LANES-1:0] optic_lane,
	output logic                     fault
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	plo_state_s state;
	plo_state_s next_state;
	logic [LANES-1:0] lane_raw;
	logic             fault_now;

	// The trip is combinational into the blocking so the outputs fall on
	// the very edge after the trip, with no extra register stage.
	assign fault_now = state.out.fault || trip;

	always_comb begin
		next_state = state;
		lane_raw   = LANES_BLOCKED;
		for (int k = 0; k < CHANNELS; k++) begin
			case (mode)
				PLO_MODE_COMPL: begin
					// restart dead time on either edge
					if (modulator[2*k] != state.prev_ref[k]) begin
						next_state.dt_count[k] = DT_WIDTH'(dead_time);
					end else if (state.dt_count[k] != '0) begin
						next_state.dt_count[k] = state.dt_count[k] - DT_WIDTH'(1'b1);
					end
					// both low while dead time runs
					if (next_state.dt_count[k] == '0) begin
						lane_raw[2*k]   = modulator[2*k];
						lane_raw[2*k+1] = ~modulator[2*k];
					end
				end
				PLO_MODE_ACTIVE: begin
					lane_raw[2*k]          = modulator[2*k] & authorize[k];
					lane_raw[2*k+1]        = authorize[k];
					next_state.dt_count[k] = '0;
				end
				default: begin
					lane_raw[2*k]          = modulator[2*k];
					lane_raw[2*k+1]        = modulator[2*k+1];
					next_state.dt_count[k] = '0;
				end
			endcase
			next_state.prev_ref[k] = modulator[2*k];
		end
		if (fault_now) begin
			next_state.out.lane  = LANES_BLOCKED;
			next_state.out.fault = !fault_clear || trip;
		end else begin
			next_state.out.lane = lane_raw;
		end
		next_state.out.optic = next_state.out.lane[OPTICAL_LANES-1:0];
	end

	// Reset leaves no dead time pending, so the first edge after release
	// already drives each pair as complementary mode asks.
	localparam plo_state_s STATE_RESET = '{
		out:      '{
			lane:  LANES_BLOCKED,
			optic: LANES_BLOCKED[OPTICAL_LANES-1:0],
			fault: 1'b0
		},
		dt_count: {CHANNELS{DEAD_TIME_RESET}},
		prev_ref: '0
	};

	always_ff @(posedge clock) begin
		if (reset) begin
			state <= STATE_RESET;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// all thirty-two lanes
	assign elec_lane  = state.out.lane;
	assign optic_lane = state.out.optic;
	assign fault      = state.out.fault;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_optic_mirror: assert property (
		@(posedge clock) disable iff (reset) optic_lane == elec_lane[OPTICAL_LANES-1:0])
		else $error("optical lane differs from electrical lane");

	a_optic_low: assert property (
		@(posedge clock) disable iff (reset) !elec_lane[0] |-> !optic_lane[0])
		else $error("optical lane zero high while electrical low");

	a_no_overlap: assert property (
		@(posedge clock) disable iff (reset)
		$past(mode) == PLO_MODE_COMPL |-> !(elec_lane[0] && elec_lane[1]))
		else $error("complementary lanes both high");

	a_trip_blocks: assert property (
		@(posedge clock) disable iff (reset) trip |=> (elec_lane == '0) && fault)
		else $error("trip did not block lanes");

	a_fault_holds: assert property (
		@(posedge clock) disable iff (reset) fault && !fault_clear |=> fault)
		else $error("fault dropped without clear");

	a_indep_follow: assert property (
		@(posedge clock) disable iff (reset)
		mode == PLO_MODE_INDEP && !fault_now |=> elec_lane[31] == $past(modulator[31]))
		else $error("independent lane did not follow modulator");

	a_auth_level: assert property (
		@(posedge clock) disable iff (reset)
		mode == PLO_MODE_ACTIVE && !fault_now |=> elec_lane[1] == $past(authorize[0]))
		else $error("authorization lane wrong");

	a_dead_time: assert property (
		@(posedge clock) disable iff (reset)
		mode == PLO_MODE_COMPL && dead_time != '0 && !fault_now
		&& $rose(modulator[0]) |=> !elec_lane[0])
		else $error("high side rose without dead time");

	a_reset_blocked: assert property (
		@(posedge clock) $past(reset) |-> elec_lane == '0 && !fault)
		else $error("lanes not blocked after reset");

	a_high_lane: assert property (
		@(posedge clock) disable iff (reset)
		mode == PLO_MODE_INDEP && !fault_now |=> elec_lane[16] == $past(modulator[16]))
		else $error("second connector lane wrong");

	a_even_lead: assert property (
		@(posedge clock) disable iff (reset)
		mode == PLO_MODE_ACTIVE && !fault_now |=> elec_lane[0] == $past(modulator[0] & authorize[0]))
		else $error("even lane is not the switching lane");

	// ------------------------------------------------------------
	// Dead time, complementary, authorization, independent, fault and reset checks
	// ------------------------------------------------------------
	a_compl_hold: assert property (
		@(posedge clock) disable iff (reset)
		mode == PLO_MODE_COMPL && !fault_now && next_state.dt_count[0] != '0
		|=> !elec_lane[0] && !elec_lane[1])
		else $error("complementary pair high during dead time");

	a_compl_inverse: assert property (
		@(posedge clock) disable iff (reset)
		mode == PLO_MODE_COMPL && !fault_now && next_state.dt_count[0] == '0
		|=> elec_lane[0] == $past(modulator[0]) && elec_lane[1] == !$past(modulator[0]))
		else $error("complementary lanes not inverse");

	a_fall_dead: assert property (
		@(posedge clock) disable iff (reset)
		mode == PLO_MODE_COMPL && dead_time != '0 && !fault_now
		&& $fell(modulator[0]) |=> !elec_lane[1])
		else $error("low side rose without dead time");

	a_dead_reload: assert property (
		@(posedge clock) disable iff (reset)
		mode == PLO_MODE_COMPL && modulator[0] != state.prev_ref[0]
		|=> state.dt_count[0] == $past(dead_time))
		else $error("dead time not reloaded on edge");

	a_auth_top: assert property (
		@(posedge clock) disable iff (reset)
		mode == PLO_MODE_ACTIVE && !fault_now |=> elec_lane[31] == $past(authorize[15]))
		else $error("top authorization lane wrong");

	a_auth_blocks: assert property (
		@(posedge clock) disable iff (reset)
		mode == PLO_MODE_ACTIVE && !authorize[15] && !fault_now |=> !elec_lane[30])
		else $error("switching lane ran without authorization");

	a_second_conn: assert property (
		@(posedge clock) disable iff (reset)
		mode == PLO_MODE_ACTIVE && !fault_now |=> elec_lane[17] == $past(authorize[8]))
		else $error("second connector authorization lane wrong");

	a_indep_all: assert property (
		@(posedge clock) disable iff (reset)
		mode == PLO_MODE_INDEP && !fault_now |=> elec_lane == $past(modulator))
		else $error("independent lanes did not follow modulators");

	a_fault_lanes: assert property (
		@(posedge clock) disable iff (reset)
		fault |-> elec_lane == '0 && optic_lane == '0)
		else $error("lanes active in fault state");

	a_fault_clears: assert property (
		@(posedge clock) disable iff (reset)
		fault && fault_clear && !trip |=> !fault)
		else $error("fault did not clear");

	a_reset_optic: assert property (
		@(posedge clock) $past(reset) |-> optic_lane == '0)
		else $error("optical lanes not blocked after reset");

endmodule

//--- common/plo_pkg.sv
package plo_pkg;

	// ------------------------------------------------------------
	// Lane geometry
	// ------------------------------------------------------------
	localparam int LANES         = 32;
	localparam int OPTICAL_LANES = 16;
	localparam int CHANNELS      = LANES / 2;
	localparam int DT_WIDTH      = 16;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [DT_WIDTH-1:0] DEAD_TIME_RESET = 16'h0000;
	localparam logic [LANES-1:0]    LANES_BLOCKED   = 32'h0000_0000;

	// Channel configuration; complementary is the value out of reset.
	typedef enum logic [2:0] {
		PLO_MODE_COMPL  = 3'h1,
		PLO_MODE_ACTIVE = 3'h2,
		PLO_MODE_INDEP  = 3'h4
	} plo_mode_e;

	typedef struct packed {
		logic [LANES-1:0]    lane;
		logic [OPTICAL_LANES-1:0] optic;
		logic                fault;
	} plo_out_s;

	typedef struct packed {
		plo_out_s                           out;
		logic [CHANNELS-1:0][DT_WIDTH-1:0]  dt_count;
		logic [CHANNELS-1:0]                prev_ref;
	} plo_state_s;

endpackage

//--- verification/plo_gate_model.sv
`timescale 1ns/1ps
module plo_gate_model
	import plo_pkg::*;
(
	// Gates seen by the drivers
	input  wire logic [LANES-1:0] gate,
	// Some pair conducting at once
	output logic                  shoot
);
	// A pair high together would short the leg, so the bench watches this.
	always_comb begin
		shoot = 1'b0;
		for (int k = 0; k < CHANNELS; k++) begin
			shoot = shoot | (gate[2*k] & gate[2*k+1]);
		end
	end
endmodule

//--- verification/plo_lane_output_tb.sv
`timescale 1ns/1ps
module plo_lane_output_tb;
	import plo_pkg::*;
	logic        clock = 1'b0;
	logic        reset = 1'b1;
	plo_mode_e   mode = PLO_MODE_COMPL;
	logic [15:0] dead_time = 16'h0000;
	logic [31:0] modulator = 32'h0000_0000;
	logic [15:0] authorize = 16'h0000;
	logic        trip = 1'b0;
	logic        fault_clear = 1'b0;
	logic [31:0] elec_lane;
	logic [15:0] optic_lane;
	logic        fault;
	logic        shoot;
	int          fails = 0;
	int          comparisons = 0;
	always #5 clock = ~clock;
	plo_lane_output plo_lane_output_inst (.clock(clock), .reset(reset), .mode(mode),
		.dead_time(dead_time), .modulator(modulator), .authorize(authorize), .trip(trip),
		.fault_clear(fault_clear), .elec_lane(elec_lane), .optic_lane(optic_lane),
		.fault(fault));
	plo_gate_model plo_gate_model_inst (.gate(elec_lane), .shoot(shoot));
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic chk(input logic [31:0] e, input logic f);
		logic [49:0] w;
		w = {f, |(e & (e >> 1) & 32'h5555_5555), e[15:0], e};
		comparisons++;
		if ({fault, shoot, optic_lane, elec_lane} !== w) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time,
				{fault, shoot, optic_lane, elec_lane}, w);
		end
	endtask
	task automatic compl_pairs();
		dead_time = 16'h0002;
		step(6);
		chk(32'hAAAA_AAAA, 1'b0);
		modulator = 32'h5555_5555;
		step(1);
		chk(32'h0000_0000, 1'b0);
		step(1);
		chk(32'h0000_0000, 1'b0);
		step(1);
		chk(32'h5555_5555, 1'b0);
		modulator = 32'h0000_0000;
		step(1);
		chk(32'h0000_0000, 1'b0);
		step(4);
		chk(32'hAAAA_AAAA, 1'b0);
		dead_time = 16'h0000;
		modulator = 32'h5555_5555;
		step(1);
		chk(32'h5555_5555, 1'b0);
		modulator = 32'h0000_0000;
		step(1);
		chk(32'hAAAA_AAAA, 1'b0);
	endtask
	task automatic indep_lanes();
		mode = PLO_MODE_INDEP;
		modulator = 32'h1234_ABCD;
		step(1);
		chk(32'h1234_ABCD, 1'b0);
		modulator = 32'hFFFF_0000;
		step(1);
		chk(32'hFFFF_0000, 1'b0);
	endtask
	task automatic auth_lanes();
		mode = PLO_MODE_ACTIVE;
		dead_time = 16'h0000;
		modulator = 32'h5555_5555;
		authorize = 16'h00FF;
		step(2);
		chk(32'h0000_FFFF, 1'b0);
		authorize = 16'hFF00;
		step(2);
		chk(32'hFFFF_0000, 1'b0);
	endtask
	task automatic trip_block();
		trip = 1'b1;
		step(1);
		chk(32'h0000_0000, 1'b1);
		trip = 1'b0;
		step(2);
		chk(32'h0000_0000, 1'b1);
		fault_clear = 1'b1;
		step(1);
		chk(32'h0000_0000, 1'b0);
		fault_clear = 1'b0;
		step(2);
		chk(32'hFFFF_0000, 1'b0);
	endtask
	task automatic reset_mid();
		trip = 1'b1;
		step(1);
		chk(32'h0000_0000, 1'b1);
		trip = 1'b0;
		reset = 1'b1;
		step(2);
		chk(32'h0000_0000, 1'b0);
		reset = 1'b0;
		step(1);
		chk(32'hFFFF_0000, 1'b0);
	endtask
	task automatic print_verdict();
		if (fails == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		step(20);
		chk(32'h0000_0000, 1'b0);
		reset = 1'b0;
		step(1);
		chk(32'hAAAA_AAAA, 1'b0);
		compl_pairs();
		indep_lanes();
		auth_lanes();
		trip_block();
		reset_mid();
		print_verdict();
	end
endmodule
